// ==== inc/wsu_params.svh ====
// Constants for the word shift unit
`ifndef WSU_PARAMS_SVH
`define WSU_PARAMS_SVH
`define WSU_WORD_W 30
`define WSU_ADDR_W 15
`define WSU_CNT_W 6
`define WSU_IDX_W 3
`define WSU_FC_SRQ 12'o0001
`define WSU_FC_SRA 12'o0002
`define WSU_FC_SRP 12'o0003
`define WSU_FC_RLQ 12'o0005
`define WSU_FC_RLA 12'o0006
`define WSU_FC_RLP 12'o0007
`define WSU_FC_LRQ 12'o7751
`define WSU_FC_LRA 12'o7755
`define WSU_FC_LRP 12'o7756
`define WSU_FC_NRM 12'o7730
`define WSU_NORM_HI 29
`define WSU_NORM_LO 28
`endif

// ==== inc/wsu_pkg.sv ====
// Types for the word shift unit
package wsu_pkg;
    typedef enum logic [2:0] {
        WSU_IDLE = 3'b001,
        WSU_NORM = 3'b010,
        WSU_DONE = 3'b100
    } wsu_state_t;
    typedef enum logic [1:0] {
        WSU_TGT_Q = 2'b00,
        WSU_TGT_A = 2'b01,
        WSU_TGT_P = 2'b10
    } wsu_tgt_t;
    typedef enum logic [1:0] {
        WSU_K_ARS = 2'b00,
        WSU_K_ROL = 2'b01,
        WSU_K_LRS = 2'b10,
        WSU_K_NRM = 2'b11
    } wsu_kind_t;
endpackage

// ==== verilog/wsu_shifter.sv ====
// Combinational 60-bit shifter used by the shift unit
`timescale 1ns/1ps
module wsu_shifter #(
    parameter int W = 60,
    parameter int CW = 6
) (
    input wire logic [W-1:0] din,
    input wire logic [CW-1:0] cnt,
    input wire logic [1:0] kind,
    input wire logic [6:0] width,
    output logic [W-1:0] dout
);
    initial begin
        if (W < 2 || (1 << CW) < W) $error("wsu_shifter: bad width");
    end
    // Operand occupies bits width-1..0; bits above are kept zero for kinds 00, 01 and 10, kind 11 passes din unchanged
    always_comb begin
        logic [W-1:0] mask;
        logic [2*W-1:0] dbl;
        logic sign;
        mask = '0;
        dbl = '0;
        sign = 1'b0;
        for (int i = 0; i < W; i++) begin
            mask[i] = (i < int'(width));
            if (i == int'(width) - 1) begin
                sign = din[i];
            end
        end
        dout = '0;
        case (kind)
            2'b00: begin
                dout = ((din >> cnt) | (sign ? ~(mask >> cnt) : '0)) & mask;
            end
            2'b01: begin
                dbl = {{W{1'b0}}, din} << cnt;
                dout = (dbl[W-1:0] | W'(dbl >> width)) & mask;
            end
            2'b10: begin
                dout = (din >> cnt) & mask;
            end
            default: begin
                dout = din;
            end
        endcase
    end
endmodule

// ==== verilog/wsu_core.sv ====
// Word shift unit: shifts on accumulator, quotient and pair_word, normalization on accumulator only
// Function
// - Codes 01,02,03 arithmetic right shift Q,A,pair
// - Codes 05,06,07 circular left shift Q,A,pair
// - Codes 7751,7755,7756 zero-fill right shift
// - Code 7730 rotates A until bits differ
// - Bit zero is least significant, rightmost
// - Address field is low 15 instruction bits
// - Operand is address field plus index
// - Accumulator shifts use exactly 30 bits
// - Pair shifts cross accumulator/quotient boundary
`timescale 1ns/1ps
`include "wsu_params.svh"
module wsu_core #(
    parameter int WORD_W = `WSU_WORD_W,
    parameter int CNT_W = `WSU_CNT_W,
    parameter int IDX_W = `WSU_IDX_W
) (
    REF_CLK,
    NRST,
    START,
    FUNC_CODE,
    INSTR_WORD,
    INDEX_VAL,
    A_IN,
    Q_IN,
    LOAD,
    BUSY,
    DONE,
    ILLEGAL,
    EFF_OPERAND,
    A_OUT,
    Q_OUT
);
    import wsu_pkg::*;
    input wire logic REF_CLK;
    input wire logic NRST;
    input wire logic START;
    input wire logic [11:0] FUNC_CODE;
    input wire logic [WORD_W-1:0] INSTR_WORD;
    input wire logic [`WSU_ADDR_W-1:0] INDEX_VAL;
    input wire logic [WORD_W-1:0] A_IN;
    input wire logic [WORD_W-1:0] Q_IN;
    input wire logic LOAD;
    output logic BUSY;
    output logic DONE;
    output logic ILLEGAL;
    output logic [`WSU_ADDR_W-1:0] EFF_OPERAND;
    output logic [WORD_W-1:0] A_OUT;
    output logic [WORD_W-1:0] Q_OUT;

    localparam int PW = 2 * WORD_W;

    initial begin
        // Normalize tests fixed bit positions and the width port is 7 bits wide
        if (WORD_W != `WSU_NORM_HI + 1 || PW > 127 || (1 << CNT_W) < PW ||
            CNT_W > `WSU_ADDR_W) begin
            $error("wsu_core: unsupported width");
        end
    end

    wsu_state_t state_reg, state_next;
    logic [WORD_W-1:0] a_reg, a_next, q_reg, q_next;
    logic done_reg, done_next, ill_reg, ill_next;
    logic [`WSU_ADDR_W-1:0] eff_reg, eff_next;
    logic [PW-1:0] sh_in, sh_out;
    logic [CNT_W-1:0] sh_cnt;
    logic [1:0] sh_kind;
    logic [6:0] sh_width;
    wsu_tgt_t tgt;
    wsu_kind_t kind;
    logic valid;
    logic [`WSU_ADDR_W-1:0] eff;

    // Decode function code into shift kind and target
    function automatic logic [4:0] decode(input logic [11:0] fc);
        case (fc)
            `WSU_FC_SRQ: decode = {1'b1, WSU_K_ARS, WSU_TGT_Q};
            `WSU_FC_SRA: decode = {1'b1, WSU_K_ARS, WSU_TGT_A};
            `WSU_FC_SRP: decode = {1'b1, WSU_K_ARS, WSU_TGT_P};
            `WSU_FC_RLQ: decode = {1'b1, WSU_K_ROL, WSU_TGT_Q};
            `WSU_FC_RLA: decode = {1'b1, WSU_K_ROL, WSU_TGT_A};
            `WSU_FC_RLP: decode = {1'b1, WSU_K_ROL, WSU_TGT_P};
            `WSU_FC_LRQ: decode = {1'b1, WSU_K_LRS, WSU_TGT_Q};
            `WSU_FC_LRA: decode = {1'b1, WSU_K_LRS, WSU_TGT_A};
            `WSU_FC_LRP: decode = {1'b1, WSU_K_LRS, WSU_TGT_P};
            `WSU_FC_NRM: decode = {1'b1, WSU_K_NRM, WSU_TGT_A};
            default: decode = {1'b0, WSU_K_ARS, WSU_TGT_Q};
        endcase
    endfunction

    always_comb begin
        logic [4:0] d;
        d = decode(FUNC_CODE);
        valid = d[4];
        kind = wsu_kind_t'(d[3:2]);
        tgt = wsu_tgt_t'(d[1:0]);
        // Carry out of the address sum is dropped: the operand wraps modulo 2^15
        eff = `WSU_ADDR_W'(INSTR_WORD[`WSU_ADDR_W-1:0] + INDEX_VAL);
        // Counts beyond the operand width are used modulo 2^CNT_W
        sh_cnt = eff[CNT_W-1:0];
        sh_kind = (kind == WSU_K_NRM) ? 2'b11 : 2'(kind);
        // Pair places accumulator in the high half
        case (tgt)
            WSU_TGT_Q: begin
                sh_in = {{WORD_W{1'b0}}, Q_IN};
                sh_width = 7'(WORD_W);
            end
            WSU_TGT_A: begin
                sh_in = {{WORD_W{1'b0}}, A_IN};
                sh_width = 7'(WORD_W);
            end
            default: begin
                sh_in = {A_IN, Q_IN};
                sh_width = 7'(PW);
            end
        endcase
    end

    wsu_shifter #(.W(PW), .CW(CNT_W)) u_shift (
        .din(sh_in),
        .cnt(sh_cnt),
        .kind(sh_kind),
        .width(sh_width),
        .dout(sh_out)
    );

    always_comb begin
        state_next = state_reg;
        a_next = a_reg;
        q_next = q_reg;
        done_next = 1'b0;
        ill_next = ill_reg;
        eff_next = eff_reg;
        case (state_reg)
            WSU_IDLE: begin
                if (LOAD) begin
                    a_next = A_IN;
                    q_next = Q_IN;
                end
                if (START) begin
                    eff_next = eff;
                    ill_next = ~valid;
                    a_next = A_IN;
                    q_next = Q_IN;
                    if (!valid) begin
                        done_next = 1'b1;
                    end else if (kind == WSU_K_NRM) begin
                        state_next = WSU_NORM;
                    end else begin
                        done_next = 1'b1;
                        case (tgt)
                            WSU_TGT_Q: q_next = sh_out[WORD_W-1:0];
                            WSU_TGT_A: a_next = sh_out[WORD_W-1:0];
                            default: begin
                                a_next = sh_out[PW-1:WORD_W];
                                q_next = sh_out[WORD_W-1:0];
                            end
                        endcase
                    end
                end
            end
            WSU_NORM: begin
                // All-zero or all-one words never normalize; stop at once without rotating
                if ((a_reg[`WSU_NORM_HI] != a_reg[`WSU_NORM_LO]) ||
                    (a_reg == '0) || (a_reg == '1)) begin
                    state_next = WSU_DONE;
                end else begin
                    a_next = {a_reg[WORD_W-2:0], a_reg[WORD_W-1]};
                end
            end
            WSU_DONE: begin
                done_next = 1'b1;
                state_next = WSU_IDLE;
            end
            default: state_next = WSU_IDLE;
        endcase
    end

    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            state_reg <= WSU_IDLE;
            a_reg <= '0;
            q_reg <= '0;
            done_reg <= 1'b0;
            ill_reg <= 1'b0;
            eff_reg <= '0;
        end else begin
            state_reg <= state_next;
            a_reg <= a_next;
            q_reg <= q_next;
            done_reg <= done_next;
            ill_reg <= ill_next;
            eff_reg <= eff_next;
        end
    end

    assign BUSY = (state_reg != WSU_IDLE);
    assign DONE = done_reg;
    assign ILLEGAL = ill_reg;
    assign EFF_OPERAND = eff_reg;
    assign A_OUT = a_reg;
    assign Q_OUT = q_reg;
endmodule

// ==== bench/wsu_core_sva.sv ====
// Assertion checker for the word shift unit
`timescale 1ns/1ps
`include "wsu_params.svh"
module wsu_core_sva #(
    parameter int WORD_W = 30,
    parameter int CNT_W = 6,
    parameter int IDX_W = 3
) (
    input wire logic REF_CLK,
    input wire logic NRST,
    input wire logic START,
    input wire logic [11:0] FUNC_CODE,
    input wire logic [WORD_W-1:0] INSTR_WORD,
    input wire logic [`WSU_ADDR_W-1:0] INDEX_VAL,
    input wire logic [WORD_W-1:0] A_IN,
    input wire logic [WORD_W-1:0] Q_IN,
    input wire logic BUSY,
    input wire logic DONE,
    input wire logic [`WSU_ADDR_W-1:0] EFF_OPERAND,
    input wire logic [WORD_W-1:0] A_OUT,
    input wire logic [WORD_W-1:0] Q_OUT
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!NRST);
    logic [29:0] a_reg, q_reg;
    logic [11:0] fc_reg;
    logic [14:0] e_reg;
    logic tk_reg;
    wire tk = START && !BUSY;
    wire [14:0] eff = INSTR_WORD[14:0] + INDEX_VAL;
    wire [5:0] c_q = e_reg[5:0];
    // Snapshot of the accepted request, compared one edge later
    always_ff @(posedge REF_CLK) begin
        tk_reg <= NRST && tk;
        if (tk) begin
            a_reg <= A_IN;
            q_reg <= Q_IN;
            fc_reg <= FUNC_CODE;
            e_reg <= eff;
        end
    end
    property p_done_one; DONE |=> !DONE; endproperty
    a_done_one: assert property (p_done_one) else $error("done longer than one cycle");
    property p_plain; tk && FUNC_CODE != `WSU_FC_NRM |=> DONE && !BUSY; endproperty
    a_plain: assert property (p_plain) else $error("plain shift not done in one cycle");
    property p_eff; tk_reg |-> EFF_OPERAND == e_reg; endproperty
    a_eff: assert property (p_eff) else $error("effective operand wrong");
    property p_sra; tk_reg && fc_reg == `WSU_FC_SRA && c_q < 30
        |-> A_OUT == 30'($signed(a_reg) >>> c_q) && Q_OUT == q_reg; endproperty
    a_sra: assert property (p_sra) else $error("sign fill shift of A wrong");
    property p_srp; tk_reg && fc_reg == `WSU_FC_SRP
        |-> {A_OUT, Q_OUT} == 60'($signed({a_reg, q_reg}) >>> c_q); endproperty
    a_srp: assert property (p_srp) else $error("sign fill pair shift wrong");
    property p_rlq; tk_reg && fc_reg == `WSU_FC_RLQ && c_q < 30
        |-> Q_OUT == ((q_reg << c_q) | (q_reg >> (30 - c_q))); endproperty
    a_rlq: assert property (p_rlq) else $error("circular shift of Q wrong");
    property p_lra; tk_reg && fc_reg == `WSU_FC_LRA |-> A_OUT == a_reg >> c_q; endproperty
    a_lra: assert property (p_lra) else $error("zero fill shift of A wrong");
    property p_norm_t; tk && FUNC_CODE == `WSU_FC_NRM |=> BUSY ##[1:31] $fell(BUSY) && DONE;
    endproperty
    a_norm_t: assert property (p_norm_t) else $error("normalize not done in time");
    property p_norm_r; DONE && fc_reg == `WSU_FC_NRM
        |-> A_OUT[29] != A_OUT[28] || A_OUT == '0 || &A_OUT; endproperty
    a_norm_r: assert property (p_norm_r) else $error("normalize result wrong");
    c_norm: cover property (tk && FUNC_CODE == `WSU_FC_NRM);
    c_pair_rot: cover property (tk_reg && fc_reg == `WSU_FC_RLP && c_q == 59);
    c_refused: cover property (START && BUSY);
endmodule
bind wsu_core wsu_core_sva #(.WORD_W(WORD_W), .CNT_W(CNT_W), .IDX_W(IDX_W)) u_sva (
    .REF_CLK(REF_CLK), .NRST(NRST), .START(START), .FUNC_CODE(FUNC_CODE),
    .INSTR_WORD(INSTR_WORD), .INDEX_VAL(INDEX_VAL), .A_IN(A_IN), .Q_IN(Q_IN),
    .BUSY(BUSY), .DONE(DONE), .EFF_OPERAND(EFF_OPERAND), .A_OUT(A_OUT), .Q_OUT(Q_OUT));

// ==== bench/wsu_core_bench.sv ====
// Self-checking testbench for the word shift unit
`timescale 1ns/1ps
`include "wsu_params.svh"
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin num_errors++; \
    $display("unexpected %s: expected %h seen %h", n, e, g); end end
module wsu_core_bench;
    logic REF_CLK = 0, NRST = 0, START = 0, LOAD = 0;
    logic [11:0] FUNC_CODE = '0;
    logic [29:0] INSTR_WORD = '0, A_IN = '0, Q_IN = '0, A_OUT, Q_OUT;
    logic [14:0] INDEX_VAL = '0, EFF_OPERAND;
    logic BUSY, DONE, ILLEGAL;
    int num_errors = 0, check_count = 0, cycles = 0;
    wsu_core i_dut (.REF_CLK(REF_CLK), .NRST(NRST), .START(START), .FUNC_CODE(FUNC_CODE),
        .INSTR_WORD(INSTR_WORD), .INDEX_VAL(INDEX_VAL), .A_IN(A_IN), .Q_IN(Q_IN), .LOAD(LOAD),
        .BUSY(BUSY), .DONE(DONE), .ILLEGAL(ILLEGAL), .EFF_OPERAND(EFF_OPERAND),
        .A_OUT(A_OUT), .Q_OUT(Q_OUT));
    always #2.5 REF_CLK = ~REF_CLK;
    always @(posedge REF_CLK) begin
        cycles++;
        if (cycles == 8000) begin
            num_errors++;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Index wraps modulo 2^15, so the operand equals c only if the add truly wraps
    task automatic run(input logic [11:0] fc, input logic [29:0] a, q, input logic [14:0] c,
        input bit poke, output int k);
        @(posedge REF_CLK);
        START <= 1'b1;
        FUNC_CODE <= fc;
        A_IN <= a;
        Q_IN <= q;
        INSTR_WORD <= {15'h4321, 15'h7FF0};
        INDEX_VAL <= c + 15'h0010;
        @(posedge REF_CLK);
        START <= 1'b0;
        if (poke) begin
            @(posedge REF_CLK);
            START <= 1'b1;
            FUNC_CODE <= `WSU_FC_SRA;
            @(posedge REF_CLK);
            START <= 1'b0;
        end
        for (k = poke ? 3 : 1; k < 40; k++) begin
            @(negedge REF_CLK);
            if (DONE === 1'b1) break;
        end
    endtask
    function automatic logic [59:0] exp_shift(logic [11:0] fc, logic [29:0] a, q, int c);
        logic [29:0] ra = a, rq = q;
        logic [59:0] p = {a, q};
        repeat (c) begin
            ra = {ra[28:0], ra[29]};
            rq = {rq[28:0], rq[29]};
            p = {p[58:0], p[59]};
        end
        case (fc)
            `WSU_FC_SRQ: return {a, 30'($signed(q) >>> c)};
            `WSU_FC_SRA: return {30'($signed(a) >>> c), q};
            `WSU_FC_SRP: return 60'($signed({a, q}) >>> c);
            `WSU_FC_RLQ: return {a, rq};
            `WSU_FC_RLA: return {ra, q};
            `WSU_FC_RLP: return p;
            `WSU_FC_LRQ: return {a, q >> c};
            `WSU_FC_LRA: return {a >> c, q};
            default: return {a, q} >> c;
        endcase
    endfunction
    task automatic t_reset();
        @(negedge REF_CLK);
        `CHK("reset A", 30'h0000_0000, A_OUT)
        `CHK("reset flags", 3'b000, {BUSY, DONE, ILLEGAL})
        @(posedge REF_CLK);
        NRST <= 1'b1;
        $display("test reset done");
    endtask
    task automatic t_shift();
        logic [11:0] fcs[9] = '{`WSU_FC_SRQ, `WSU_FC_SRA, `WSU_FC_SRP, `WSU_FC_RLQ,
            `WSU_FC_RLA, `WSU_FC_RLP, `WSU_FC_LRQ, `WSU_FC_LRA, `WSU_FC_LRP};
        logic [29:0] av, qv;
        int c, k;
        for (int v = 0; v < 2; v++) begin
            av = v ? 30'h1234_5678 : 30'h2345_6789;
            qv = v ? 30'h0F0F_1234 : 30'h3C0F_00F1;
            foreach (fcs[i]) for (int j = 0; j < 3; j++) begin
                c = (j < 2) ? j : ((i % 3 == 2) ? 59 : 29);
                run(fcs[i], av, qv, 15'(c), 1'b0, k);
                `CHK("shift", exp_shift(fcs[i], av, qv, c), {A_OUT, Q_OUT})
                `CHK("latency", 1, k)
                `CHK("operand", 15'(c), EFF_OPERAND)
            end
        end
        $display("test shift done");
    endtask
    task automatic t_norm();
        logic [29:0] vals[5] = '{30'h0000_0001, 30'h0000_0003, 30'h0000_0000,
            30'h3FFF_FFFF, 30'h2000_0000};
        logic [29:0] r;
        int n, k;
        foreach (vals[i]) begin
            r = vals[i];
            for (n = 0; r[29] == r[28] && r != '0 && ~&r; n++)
                r = {r[28:0], r[29]};
            run(`WSU_FC_NRM, vals[i], 30'h0000_0005, 15'h0007, i == 0, k);
            `CHK("normalized", r, A_OUT)
            `CHK("normalize cycles", n + 3, k)
        end
        $display("test normalize done");
    endtask
    task automatic t_misc();
        int k;
        run(12'o0004, 30'h1555_5555, 30'h0AAA_AAAA, 15'h0003, 1'b0, k);
        `CHK("illegal", 31'h5555_5555, {ILLEGAL, A_OUT})
        @(posedge REF_CLK);
        LOAD <= 1'b1;
        A_IN <= 30'h0123_4567;
        Q_IN <= 30'h3210_7654;
        @(posedge REF_CLK);
        LOAD <= 1'b0;
        @(negedge REF_CLK);
        `CHK("load", 60'h048_D159_F210_7654, {A_OUT, Q_OUT})
        run(`WSU_FC_LRA, 30'h2000_0000, 30'h0000_0000, 15'h001D, 1'b0, k);
        `CHK("legal after illegal", 31'h0000_0001, {ILLEGAL, A_OUT})
        $display("test misc done");
    endtask
    initial begin
        repeat (4) @(posedge REF_CLK);
        t_reset();
        t_shift();
        t_norm();
        t_misc();
        finish_test();
    end
endmodule
